/* File: rtl/pps_pkg.sv */
package pps_pkg;
	// Timing base
	localparam int CLK_MHZ       = 100;
	localparam int TMR_W         = 24;
	// Times in microseconds, as specified
	localparam int INR_DEL_US    = 81500;
	localparam int FOLD_DEG_US   = 1650;
	localparam int IND_DELAY_US  = 24000;
	localparam int BIAS_TO_US    = 50000;
	localparam int LCF_US        = 81500;
	// Cycle counts derived from the clock rate
	localparam int INR_DEL_CYC   = INR_DEL_US * CLK_MHZ;
	localparam int FOLD_DEG_CYC  = FOLD_DEG_US * CLK_MHZ;
	localparam int IND_DELAY_CYC = IND_DELAY_US * CLK_MHZ;
	localparam int BIAS_TO_CYC   = BIAS_TO_US * CLK_MHZ;
	localparam int LCF_CYC       = LCF_US * CLK_MHZ;
	// Current limits in mA
	localparam logic [11:0] ILIM_INR_STD = 12'h0C8;
	localparam logic [11:0] ILIM_INR_HI  = 12'h14F;
	localparam logic [11:0] ILIM_OP_STD  = 12'h73A;
	localparam logic [11:0] ILIM_OP_HI   = 12'h898;
	// Class event counting
	localparam logic [2:0] CLS_FIRST_MAX = 3'h2;
	localparam logic [2:0] CLS_SAT       = 3'h5;
	// Register map
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam int CTRL_VARIANT_BIT      = 0;
	localparam logic CTRL_VARIANT_RST    = 1'b0;
	localparam int ST_STATE_LSB          = 0;
	localparam int ST_CNT_LSB            = 4;
	localparam int ST_TYPE34_BIT         = 8;
	localparam int ST_IND_LSB            = 12;
	// Sequencer states
	typedef enum logic [2:0] {
		PPS_OFF     = 3'b000,
		PPS_INRUSH  = 3'b001,
		PPS_STARTUP = 3'b010,
		PPS_DELAY   = 3'b011,
		PPS_RUN     = 3'b100
	} pps_state_t;
	// Comparator levels from the analog front end
	typedef struct packed {
		logic aux_adapter_detect;
		logic vdd_above_uvlo;
		logic vdd_above_mark_reset;
		logic vdd_in_detect_win;
		logic vdd_in_class_win;
		logic vdd_above_ind_thr;
		logic detect_enable_pin_low;
		logic thermal_shutdown;
		logic load_return_cur_low;
		logic load_return_foldback;
		logic bias_feedback_in;
		logic bias_supply_uv;
	} pps_sense_t;
	// Open-drain pin group
	typedef struct packed {
		logic inrush_done_out;
		logic high_type_indicator;
		logic low_type_indicator;
		logic enhanced_pse_indicator;
	} pps_od_t;
	// Power path controls
	typedef struct packed {
		logic        pass_switch_on;
		logic [11:0] ilim_ma;
		logic        class_sig_first;
		logic        class_sig_later;
		logic        detect_sig_on;
		logic        hold_power_signature;
		logic        bias_supply_out_on;
		logic        startup_source_on;
	} pps_pwr_t;
endpackage : pps_pkg

/* File: rtl/pps_timer.sv */
`timescale 1ns/1ps
// Elapsed-time counter: done rises once run has held for limit cycles
module pps_timer (
	// Clock and reset
	input  wire logic                      mclk_i,
	input  wire logic                      reset_n_i,
	// Control
	input  wire logic                      run_i,
	input  wire logic [pps_pkg::TMR_W-1:0] limit_i,
	// Status
	output logic                           done_o
);
	import pps_pkg::*;
	typedef struct packed {
		logic [TMR_W-1:0] cnt; // Cycles elapsed
		logic             done; // Limit reached
	} pps_tmr_t;
	pps_tmr_t r;
	pps_tmr_t next_r;
	// Count while running; dropping run restarts from zero
	always_comb begin
		next_r = r;
		if (!run_i) begin
			next_r.cnt  = '0;
			next_r.done = 1'b0;
		end else if (r.cnt != limit_i) begin
			next_r.cnt = r.cnt + TMR_W'(1);
		end
		if (run_i)
			next_r.done = (next_r.cnt == limit_i);
	end
	// State register
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			r <= '0;
		else
			r <= next_r;
	end
	assign done_o = r.done;
endmodule : pps_timer

/* File: rtl/pps_regs.sv */
`timescale 1ns/1ps
// Register slave: control word and status readback
module pps_regs (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	// Software port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic [31:0]      reg_rdata_o,
	// Block side
	input  wire logic [31:0] status_i,
	output logic             variant_hi_o
);
	import pps_pkg::*;
	typedef struct packed {
		logic        variant; // Selects the higher power variant
		logic [31:0] rdata;   // Read data, valid one cycle
	} pps_reg_t;
	pps_reg_t r;
	pps_reg_t next_r;
	// Decode; unmapped reads return zero, unmapped writes are dropped
	always_comb begin
		next_r       = r;
		next_r.rdata = '0;
		if (reg_wr_i && reg_addr_i == ADDR_CTRL)
			next_r.variant = reg_wdata_i[CTRL_VARIANT_BIT];
		if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_CTRL:   next_r.rdata = {31'h0, r.variant};
				ADDR_STATUS: next_r.rdata = status_i;
				default:     next_r.rdata = '0;
			endcase
		end
	end
	// State register
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r.variant <= CTRL_VARIANT_RST;
			r.rdata   <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign reg_rdata_o  = r.rdata;
	assign variant_hi_o = r.variant;
endmodule : pps_regs

/* File: rtl/pps_seq.sv */
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module pps_seq #(
	parameter logic [pps_pkg::TMR_W-1:0] INR_DEL_CYC   = pps_pkg::TMR_W'(pps_pkg::INR_DEL_CYC),
	parameter logic [pps_pkg::TMR_W-1:0] FOLD_DEG_CYC  = pps_pkg::TMR_W'(pps_pkg::FOLD_DEG_CYC),
	parameter logic [pps_pkg::TMR_W-1:0] IND_DELAY_CYC = pps_pkg::TMR_W'(pps_pkg::IND_DELAY_CYC),
	parameter logic [pps_pkg::TMR_W-1:0] BIAS_TO_CYC   = pps_pkg::TMR_W'(pps_pkg::BIAS_TO_CYC),
	parameter logic [pps_pkg::TMR_W-1:0] LCF_CYC       = pps_pkg::TMR_W'(pps_pkg::LCF_CYC)
) (
	// Clock and reset
	input  wire logic                sense_dummy_unused_n_i,
	input  wire logic                mclk_i,
	input  wire logic                reset_n_i,
	// Analog comparator levels
	input  wire pps_pkg::pps_sense_t sense_i,
	// Open-drain pins
	input  wire pps_pkg::pps_od_t    od_in_i,
	output pps_pkg::pps_od_t         od_out_o,
	output pps_pkg::pps_od_t         od_oe_o,
	// Power path controls
	output pps_pkg::pps_pwr_t        pwr_o,
	// Register port
	input  wire logic [7:0]          reg_addr_i,
	input  wire logic [31:0]         reg_wdata_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	output logic [31:0]              reg_rdata_o
);
	import pps_pkg::*;

	// Returns {high_type_low, low_type_low, enhanced_low}
	function automatic logic [2:0] ind_code(input logic [2:0] cnt, input logic t34);
		logic lo_type_low;
		logic hi_type_low;
		lo_type_low = (cnt == 3'h2) || (cnt == 3'h3) || (cnt == 3'h5);
		hi_type_low = (cnt >= 3'h4);
		ind_code    = {hi_type_low, lo_type_low, t34};
	endfunction : ind_code

	// Whole sequencer state
	typedef struct packed {
		pps_state_t st;         // Sequencer phase
		logic [2:0] cls_cnt;    // Class events seen
		logic       in_cls;     // Inside class window last cycle
		logic       type34;     // Long first event seen
		logic       cur_seen;   // Inrush current has dropped
		logic       skip_delay; // Foldback re-entry skips delay
		pps_pwr_t   pwr;        // Power path outputs
		pps_od_t    oe;         // Open-drain enables
	} pps_seq_t;
	pps_seq_t r;
	pps_seq_t next_r;

	// Timer handshakes, variant select, status word and fault
	logic variant_hi;    // Higher power variant selected
	logic inr_done;      // Minimum inrush delay elapsed
	logic fold_done;     // Foldback held past deglitch
	logic ind_done;      // Indicator delay elapsed
	logic bto_done;      // Bias feedback wait timed out
	logic lcf_done;      // First class event was long
	logic [31:0] status; // Status word for readback
	logic        fault;  // Any condition that opens the switch

	// Timers run from the current phase, the foldback timer only while foldback is sensed; the long-class timer runs from the class window and count
	pps_timer u_inr (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.run_i     (r.st == PPS_INRUSH),
		.limit_i   (INR_DEL_CYC),
		.done_o    (inr_done)
	);
	pps_timer u_fold (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.run_i     (sense_i.load_return_foldback && r.st inside {PPS_STARTUP, PPS_DELAY, PPS_RUN}),
		.limit_i   (FOLD_DEG_CYC),
		.done_o    (fold_done)
	);
	pps_timer u_ind (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.run_i     (r.st == PPS_DELAY),
		.limit_i   (IND_DELAY_CYC),
		.done_o    (ind_done)
	);
	pps_timer u_bto (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.run_i     (r.st == PPS_STARTUP),
		.limit_i   (BIAS_TO_CYC),
		.done_o    (bto_done)
	);
	pps_timer u_lcf (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.run_i     (sense_i.vdd_in_class_win && r.cls_cnt == 3'h1),
		.limit_i   (LCF_CYC),
		.done_o    (lcf_done)
	);

	// Software port; status shows phase, count and indicator code
	assign status = {16'h0, 1'b0, ind_code(r.cls_cnt, r.type34), 3'h0, r.type34,
		1'b0, r.cls_cnt, 1'b0, r.st};
	pps_regs u_regs (
		.mclk_i       (mclk_i),
		.reset_n_i    (reset_n_i),
		.reg_addr_i   (reg_addr_i),
		.reg_wdata_i  (reg_wdata_i),
		.reg_wr_i     (reg_wr_i),
		.reg_rd_i     (reg_rd_i),
		.reg_rdata_o  (reg_rdata_o),
		.status_i     (status),
		.variant_hi_o (variant_hi)
	);

	// Switch-opening conditions; recovery always passes through inrush
	assign fault = !sense_i.vdd_above_uvlo || sense_i.thermal_shutdown ||
		sense_i.detect_enable_pin_low || sense_i.aux_adapter_detect;

	// Next-state and output logic
	always_comb begin
		logic [2:0] code;
		logic       ind_on;
		code   = 3'h0;
		ind_on = 1'b0;
		next_r = r;
		// Class events and PSE type, held until mark reset
		next_r.in_cls = sense_i.vdd_in_class_win;
		if (sense_i.vdd_in_class_win && !r.in_cls && r.cls_cnt != CLS_SAT)
			next_r.cls_cnt = r.cls_cnt + 3'h1;
		if (lcf_done)
			next_r.type34 = 1'b1;
		if (!sense_i.vdd_above_mark_reset) begin
			next_r.cls_cnt = 3'h0;
			next_r.type34  = 1'b0;
			next_r.in_cls  = 1'b0;
		end
		// Phase sequencing
		case (r.st)
			PPS_OFF: begin
				if (!fault) begin
					next_r.st         = PPS_INRUSH;
					next_r.cur_seen   = 1'b0;
					next_r.skip_delay = 1'b0;
				end
			end
			PPS_INRUSH: begin
				if (sense_i.load_return_cur_low)
					next_r.cur_seen = 1'b1;
				if (sense_i.load_return_cur_low && (inr_done || r.skip_delay)) begin
					// Feedback already up: indicator delay starts now
					next_r.st = sense_i.bias_feedback_in ? PPS_DELAY : PPS_STARTUP;
				end
			end
			PPS_STARTUP: begin
				if (sense_i.bias_feedback_in || bto_done)
					next_r.st = PPS_DELAY;
			end
			PPS_DELAY: begin
				if (sense_i.bias_supply_uv)
					next_r.st = PPS_STARTUP;
				else if (ind_done)
					next_r.st = PPS_RUN;
			end
			PPS_RUN: begin
				if (sense_i.bias_supply_uv)
					next_r.st = PPS_STARTUP;
			end
			default: next_r.st = PPS_OFF;
		endcase
		// Deglitched foldback re-enters inrush without the delay term
		if (fold_done && r.st != PPS_OFF && r.st != PPS_INRUSH) begin
			next_r.st         = PPS_INRUSH;
			next_r.cur_seen   = 1'b0;
			next_r.skip_delay = 1'b1;
		end
		if (fault)
			next_r.st = PPS_OFF;
		// Pass switch and its limit
		next_r.pwr.pass_switch_on = (next_r.st != PPS_OFF);
		if (next_r.st == PPS_INRUSH && !next_r.cur_seen)
			next_r.pwr.ilim_ma = variant_hi ? ILIM_INR_HI : ILIM_INR_STD;
		else
			next_r.pwr.ilim_ma = variant_hi ? ILIM_OP_HI : ILIM_OP_STD;
		// Signatures; class regulator off under aux or detect-enable low
		next_r.pwr.detect_sig_on = sense_i.vdd_in_detect_win;
		next_r.pwr.class_sig_first = sense_i.vdd_in_class_win && !sense_i.aux_adapter_detect &&
			!sense_i.detect_enable_pin_low && next_r.cls_cnt <= CLS_FIRST_MAX;
		next_r.pwr.class_sig_later = sense_i.vdd_in_class_win && !sense_i.aux_adapter_detect &&
			!sense_i.detect_enable_pin_low && next_r.cls_cnt > CLS_FIRST_MAX;
		// Bias path; aux skips every delay
		next_r.pwr.startup_source_on = sense_i.aux_adapter_detect ||
			next_r.st inside {PPS_STARTUP, PPS_DELAY};
		next_r.pwr.bias_supply_out_on = next_r.st inside {PPS_DELAY, PPS_RUN};
		next_r.pwr.hold_power_signature = sense_i.aux_adapter_detect ||
			next_r.st == PPS_RUN;
		// Indicator pins; the count is kept, only the drive is gated
		code   = ind_code(next_r.cls_cnt, next_r.type34);
		ind_on = next_r.st == PPS_RUN && !sense_i.bias_supply_uv &&
			sense_i.vdd_above_ind_thr && !sense_i.thermal_shutdown;
		next_r.oe.inrush_done_out        = (next_r.st == PPS_INRUSH);
		next_r.oe.high_type_indicator    = ind_on && code[2];
		next_r.oe.low_type_indicator     = ind_on && code[1];
		next_r.oe.enhanced_pse_indicator = ind_on && code[0];
		if (sense_i.aux_adapter_detect) begin
			next_r.oe                     = '0;
			next_r.oe.high_type_indicator = 1'b1;
		end
	end

	// State register
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Open-drain pins only ever pull low; the read-back input is unused here
	assign od_out_o = '0;
	assign od_oe_o  = r.oe;
	assign pwr_o    = r.pwr;

	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	aux_pass_off_a: assert property (sense_i.aux_adapter_detect |=> !pwr_o.pass_switch_on &&
		!pwr_o.class_sig_first && !pwr_o.class_sig_later) else $error("aux left switch or class on");
	aux_pins_a: assert property (sense_i.aux_adapter_detect |=> od_oe_o == 4'h4)
		else $error("aux pin states wrong");
	aux_bias_a: assert property (sense_i.aux_adapter_detect |=> pwr_o.startup_source_on)
		else $error("aux did not enable bias");
	aux_hold_a: assert property (sense_i.aux_adapter_detect |=> pwr_o.hold_power_signature)
		else $error("aux did not enable hold signature");
	inrush_pin_a: assert property (od_oe_o.inrush_done_out == (r.st == PPS_INRUSH))
		else $error("inrush pin drive mismatch");
	class_sel_a: assert property (pwr_o.class_sig_later |-> r.cls_cnt >= 3'h3 &&
		!pwr_o.class_sig_first) else $error("wrong class resistor");
	detect_win_a: assert property (pwr_o.detect_sig_on == $past(sense_i.vdd_in_detect_win))
		else $error("detect signature outside window");
	den_off_a: assert property (sense_i.detect_enable_pin_low |=> !pwr_o.pass_switch_on)
		else $error("detect-enable low left switch on");
	inrush_end_a: assert property ($past(r.st == PPS_INRUSH) && r.st inside {PPS_STARTUP, PPS_DELAY}
		|-> $past(inr_done || r.skip_delay) && $past(sense_i.load_return_cur_low))
		else $error("inrush ended early");
	ind_float_a: assert property (sense_i.thermal_shutdown || sense_i.bias_supply_uv
		|=> od_oe_o[2:0] == 3'h0 || od_oe_o == 4'h4) else $error("indicators driven in fault");
	count_sat_a: assert property (r.cls_cnt <= CLS_SAT)
		else $error("class count past saturation");

	reach_run_c: cover property (r.st == PPS_DELAY ##1 r.st == PPS_RUN);
	fold_c: cover property (r.st == PPS_RUN ##1 r.st == PPS_INRUSH);
	five_ev_c: cover property (r.cls_cnt == CLS_SAT);
	aux_c: cover property (sense_i.aux_adapter_detect ##1 pwr_o.startup_source_on);
endmodule : pps_seq

/* File: dv/pps_pse_model.sv */
`timescale 1ns/1ps
// Cable-side source: steps the input voltage through the detect, class and power ranges
module pps_pse_model #(
	parameter int LCF = 15
) (
	// Clock
	input  wire logic mclk_i,
	// Voltage range levels seen by the device
	output logic      mark_o,
	output logic      det_o,
	output logic      cls_o,
	output logic      uvlo_o,
	output logic      ind_o
);
	// Cable starts unpowered
	initial begin
		{mark_o, det_o, cls_o, uvlo_o, ind_o} = 5'h00;
	end
	// Port shut off: the input collapses below mark reset
	task automatic cable_off();
		@(posedge mclk_i);
		{mark_o, det_o, cls_o, uvlo_o, ind_o} <= 5'h00;
	endtask : cable_off
	// Detection probe followed by n class events, the first one optionally long
	task automatic probe(input int n, input bit long_first);
		int len;
		if (n > 5) n = 5;
		@(posedge mclk_i);
		mark_o <= 1'b1;
		det_o  <= 1'b1;
		repeat (3) @(posedge mclk_i);
		det_o <= 1'b0;
		for (int i = 0; i < n; i++) begin
			// A long first event tells the device the source is type 3-4
			len = (long_first && i == 0) ? LCF + 5 : 4;
			cls_o <= 1'b1;
			repeat (len) @(posedge mclk_i);
			// Between events the voltage drops back to the mark range
			cls_o <= 1'b0;
			repeat (3) @(posedge mclk_i);
		end
	endtask : probe
	// Full operating voltage, above lockout and the indicator threshold
	task automatic power_on();
		@(posedge mclk_i);
		uvlo_o <= 1'b1;
		ind_o  <= 1'b1;
	endtask : power_on
endmodule : pps_pse_model

/* File: dv/test_poe_pd_startup_sequencer.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
	$display("wrong value %s expected %0h seen %0h", nm, e, g); end end
`define WAIT_UNTIL(c, n) begin int k; k = 0; while (!(c) && k < (n)) begin @(negedge mclk_i); k++; end end
// Self-checking bench for the startup sequencer
module test_poe_pd_startup_sequencer;
	import pps_pkg::*;
	// Shortened timer values keep the run brief
	localparam int INR = 20;
	localparam int FOLD = 5;
	localparam int IND = 10;
	localparam int BTO = 30;
	localparam int LCF = 15;
	logic             mclk_i, reset_n_i;
	logic             aux, en_low, th, cur_low, fold, fb, buv, ind_ok;
	logic             mark, det, cls, uvlo, ind;
	pps_sense_t       sense;
	pps_od_t          oe, od_out;
	pps_pwr_t         pwr;
	logic [7:0]       reg_addr;
	logic [31:0]      reg_wdata, reg_rdata, d;
	logic             reg_wr, reg_rd, cls_q, cls_qq;
	logic             det_q, det_qq; // Detect window delayed by one and two cycles
	logic [31:0]      seed = 32'd37992;
	int               err_count, check_count, cycles, cls_cnt, n;
	bit               long_f, var_hi, fb_early;
	logic [2:0]       exp_ind;
	// Device under test
	pps_seq #(.INR_DEL_CYC(TMR_W'(INR)), .FOLD_DEG_CYC(TMR_W'(FOLD)), .IND_DELAY_CYC(TMR_W'(IND)),
		.BIAS_TO_CYC(TMR_W'(BTO)), .LCF_CYC(TMR_W'(LCF))) dut (
		.sense_dummy_unused_n_i(1'b1), .mclk_i(mclk_i), .reset_n_i(reset_n_i), .sense_i(sense),
		.od_in_i(~oe), .od_out_o(od_out), .od_oe_o(oe), .pwr_o(pwr), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
	// Power source on the far end of the cable
	pps_pse_model #(.LCF(LCF)) u_pse (.mclk_i(mclk_i), .mark_o(mark), .det_o(det), .cls_o(cls),
		.uvlo_o(uvlo), .ind_o(ind));
	// Comparator levels merged from the source model and bench-driven faults
	always_comb begin
		sense = '0;
		sense.aux_adapter_detect = aux;
		sense.vdd_above_uvlo = uvlo;
		sense.vdd_above_mark_reset = mark;
		sense.vdd_in_detect_win = det;
		sense.vdd_in_class_win = cls;
		sense.vdd_above_ind_thr = ind & ind_ok;
		sense.detect_enable_pin_low = en_low;
		sense.thermal_shutdown = th;
		sense.load_return_cur_low = cur_low;
		sense.load_return_foldback = fold;
		sense.bias_feedback_in = fb;
		sense.bias_supply_uv = buv;
	end
	// Clock at 100 MHz
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	// Xorshift source, fixed seed so runs repeat
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// Indicator code {high, low, enhanced} expected from event count and source type
	function automatic logic [2:0] ind_code(input int c, input bit t34);
		return {(c == 4 || c == 5), (c == 2 || c == 3 || c == 5), t34};
	endfunction : ind_code
	// Own count of class events, cleared below mark reset
	always @(posedge mclk_i) begin
		cls_q <= cls;
		cls_qq <= cls_q;
		det_q <= det;
		det_qq <= det_q;
		if (!mark)
			cls_cnt <= 0;
		else if (cls_q && !cls_qq && cls_cnt < 5)
			cls_cnt <= cls_cnt + 1;
	end
	// Signature switching watched while a window has lasted two cycles
	always @(negedge mclk_i) begin
		if (reset_n_i && !uvlo && !aux && cls_q && cls_qq && cls) begin
			`CHK("class_sig_first", (cls_cnt <= 2), pwr.class_sig_first)
			`CHK("class_sig_later", (cls_cnt > 2), pwr.class_sig_later)
			`CHK("detect_sig_on", 1'b0, pwr.detect_sig_on)
		end
		if (reset_n_i && !uvlo && det && det_q && det_qq)
			`CHK("detect_sig_on", 1'b1, pwr.detect_sig_on)
	end
	// Hang guard: the tests need a few hundred cycles
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			$display("wrong value timeout expected 0 seen %0d", cycles);
			end_sim();
		end
	end
	// Register write, one strobe cycle
	task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk_i);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk_i);
		reg_wr <= 1'b0;
	endtask : reg_write
	// Register read, data taken in the cycle after the strobe
	task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk_i);
		reg_rd <= 1'b0;
		@(negedge mclk_i);
		v = reg_rdata;
	endtask : reg_read
	// Counts, verdict and end of run
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	// Main sequence
	initial begin
		{aux, en_low, th, cur_low, fold, fb, buv, reg_wr, reg_rd} = '0;
		ind_ok = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reset_n_i = 1'b0;
		repeat (2) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		@(negedge mclk_i);
		`CHK("oe after reset", 4'h0, oe)
		reg_read(ADDR_CTRL, d);
		`CHK("ctrl reset", 32'h0, d)
		reg_write(8'h08, 32'hFFFFFFFF);
		reg_read(8'h08, d);
		`CHK("unmapped read", 32'h0, d)
		for (int r = 0; r < 4; r++) begin
			n = (r == 3) ? 5 : 1 + int'(xs() % 5);
			d = xs();
			{long_f, var_hi, fb_early} = d[2:0];
			u_pse.cable_off();
			repeat (3) @(posedge mclk_i);
			reg_read(ADDR_STATUS, d);
			`CHK("count cleared", 3'h0, d[6:4])
			reg_write(ADDR_CTRL, {31'h0, var_hi});
			u_pse.probe(n, long_f);
			reg_read(ADDR_STATUS, d);
			`CHK("class count", 3'(n), d[6:4])
			`CHK("type 3-4", long_f, d[8])
			exp_ind = ind_code(n, long_f);
			@(posedge mclk_i);
			fb <= fb_early;
			cur_low <= 1'b0;
			u_pse.power_on();
			`WAIT_UNTIL(oe.inrush_done_out === 1'b1, 5)
			`CHK("pass switch", 1'b1, pwr.pass_switch_on)
			`CHK("inrush limit", var_hi ? ILIM_INR_HI : ILIM_INR_STD, pwr.ilim_ma)
			@(posedge mclk_i);
			cur_low <= 1'b1;
			repeat (5) @(negedge mclk_i);
			`CHK("inrush held", 1'b1, oe.inrush_done_out)
			`WAIT_UNTIL(oe.inrush_done_out === 1'b0, INR + 10)
			`CHK("operating limit", var_hi ? ILIM_OP_HI : ILIM_OP_STD, pwr.ilim_ma)
			@(posedge mclk_i);
			fb <= 1'b1;
			`WAIT_UNTIL(pwr.bias_supply_out_on === 1'b1, 5)
			`CHK("bias switch", 1'b1, pwr.bias_supply_out_on)
			repeat (IND - 3) @(negedge mclk_i);
			`CHK("indicators early", 3'h0, oe[2:0])
			`WAIT_UNTIL(oe[2:0] === exp_ind, 8)
			`CHK("indicators", exp_ind, oe[2:0])
			// Thermal shutdown, bias undervoltage, low input: float, then restore
			for (int f = 0; f < 3; f++) begin
				@(posedge mclk_i);
				{th, buv, ind_ok} <= (f == 0) ? 3'b101 : (f == 1) ? 3'b011 : 3'b000;
				`WAIT_UNTIL(oe[2:0] === 3'h0, 4)
				`CHK("indicators floated", 3'h0, oe[2:0])
				@(posedge mclk_i);
				{th, buv, ind_ok} <= 3'b001;
				`WAIT_UNTIL(oe[2:0] === exp_ind, INR + IND + 40)
				`CHK("indicators restored", exp_ind, oe[2:0])
			end
			@(posedge mclk_i);
			fold <= 1'b1;
			repeat (FOLD - 2) @(negedge mclk_i);
			`CHK("foldback deglitch", 1'b0, oe.inrush_done_out)
			`WAIT_UNTIL(oe.inrush_done_out === 1'b1, 8)
			`CHK("foldback inrush", 1'b1, oe.inrush_done_out)
			@(posedge mclk_i);
			fold <= 1'b0;
			`WAIT_UNTIL(oe.inrush_done_out === 1'b0, INR - 8)
			`CHK("inrush delay skipped", 1'b0, oe.inrush_done_out)
			@(posedge mclk_i);
			en_low <= 1'b1;
			`WAIT_UNTIL(pwr.pass_switch_on === 1'b0, 4)
			`CHK("detect enable off", 3'h0, {pwr.pass_switch_on, pwr.class_sig_first, pwr.class_sig_later})
			@(posedge mclk_i);
			en_low <= 1'b0;
			aux <= 1'b1;
			repeat (4) @(negedge mclk_i);
			`CHK("aux pass", 3'h0, {pwr.pass_switch_on, pwr.class_sig_first, pwr.class_sig_later})
			`CHK("aux pins", 4'h4, oe)
			`CHK("aux startup", 1'b1, pwr.startup_source_on)
			`CHK("aux hold signature", 1'b1, pwr.hold_power_signature)
			@(posedge mclk_i);
			aux <= 1'b0;
			$display("test %0d done: %0d events", r, n);
		end
		end_sim();
	end
endmodule : test_poe_pd_startup_sequencer
